/* rtl/sdpi_defines.svh */
// sdpi_defines.svh: widths, field positions, reset values and counts of the
// synchronous dram pin interface.
// assumes: guarded, so every file may include it; macros are global.
`ifndef SDPI_DEFINES_SVH
`define SDPI_DEFINES_SVH
// -----------------------------------------------------------------------
// pin widths
// -----------------------------------------------------------------------
`define SDPI_ROW_W 12
`define SDPI_COL_W 8
`define SDPI_BANK_W 2
`define SDPI_BANKS 4
`define SDPI_DQ_W 16
`define SDPI_DQM_W 2
// -----------------------------------------------------------------------
// address and op-code fields
// -----------------------------------------------------------------------
`define SDPI_AP_BIT 10
`define SDPI_BL_LSB 0
`define SDPI_CL_LSB 4
`define SDPI_WB_SINGLE_BIT 9
// burst length 1, latency 2
`define SDPI_MODE_RST 12'h020
// -----------------------------------------------------------------------
// timing counts in clock cycles
// -----------------------------------------------------------------------
`define SDPI_DQM_RD_LAT 2
`define SDPI_CKE_SYNC 3
`define SDPI_T_RCD_CYC 2
`define SDPI_T_RP_CYC 2
`define SDPI_T_WAKE_CYC 4
`endif

/* rtl/sdpi_pkg.sv */
// sdpi_pkg: command and power-state types shared by both ends.
// assumes: sdpi_defines.svh is on the include path.
package sdpi_pkg;
  `include "sdpi_defines.svh"

  // {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDPI_LMR   = 4'b0000,
    SDPI_REF   = 4'b0001,
    SDPI_PRE   = 4'b0010,
    SDPI_ACT   = 4'b0011,
    SDPI_WR    = 4'b0100,
    SDPI_RD    = 4'b0101,
    SDPI_BST   = 4'b0110,
    SDPI_NOP   = 4'b0111,
    SDPI_DESEL = 4'b1111
  } sdpi_cmd_t;

  typedef enum logic [1:0] {
    SDPI_RUN  = 2'b00,
    SDPI_PDN  = 2'b01,
    SDPI_SUSP = 2'b10,
    SDPI_SREF = 2'b11
  } sdpi_pwr_t;

  // chip select high masks the strobes entirely
  function automatic sdpi_cmd_t sdpi_decode(input logic cs_n,
      input logic ras_n, input logic cas_n, input logic we_n);
    if (cs_n)
      return SDPI_DESEL;
    return sdpi_cmd_t'({1'b0, ras_n, cas_n, we_n});
  endfunction
endpackage

/* rtl/sdpi_if.sv */
// sdpi_if: pins between the memory controller and the dram device.
// assumes: both ends run on one clock; dq is resolved here per byte.
`timescale 1ns/1ps
`include "sdpi_defines.svh"
interface sdpi_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [`SDPI_BANK_W-1:0] ba;
  logic [`SDPI_ROW_W-1:0] addr;
  logic [`SDPI_DQM_W-1:0] dqm;
  logic [`SDPI_DQ_W-1:0] ctl_dq;
  logic [`SDPI_DQM_W-1:0] ctl_dq_oe;
  logic [`SDPI_DQ_W-1:0] dev_dq;
  logic [`SDPI_DQM_W-1:0] dev_dq_oe;
  logic [`SDPI_DQ_W-1:0] dq;

  // undriven byte shows the inverse of the controller's last value, so a
  // missing device drive cannot pass as good data
  always_comb begin
    for (int b = 0; b < `SDPI_DQM_W; b++)
      dq[8*b +: 8] = dev_dq_oe[b] ? dev_dq[8*b +: 8] :
        (ctl_dq_oe[b] ? ctl_dq[8*b +: 8] : ~ctl_dq[8*b +: 8]);
  end

  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
    ctl_dq, ctl_dq_oe, input dq);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
    output dev_dq, dev_dq_oe);
endinterface

/* rtl/sdpi_ctl.sv */
// sdpi_ctl: controller end; one access per request, with a two-entry
// read buffer toward the user.
// assumes: shares clk_sys_in with the device end; pins via sdpi_if.ctl.
`timescale 1ns/1ps
`include "sdpi_defines.svh"
module sdpi_ctl import sdpi_pkg::*; #(
  parameter int CAS_LAT = 2,
  parameter int T_RCD_CYC = `SDPI_T_RCD_CYC,
  parameter int T_RP_CYC = `SDPI_T_RP_CYC,
  parameter int T_WAKE_CYC = `SDPI_T_WAKE_CYC
) (
  input wire logic clk_sys_in, // system clock
  input wire logic rstn_in, // async reset, active low
  sdpi_if.ctl pin, // memory pins
  input wire logic req_valid_in, // request offered
  output logic req_ready_out, // request taken
  input wire logic req_write_in, // 1 write, 0 read
  input wire logic [1:0] req_bank_in, // bank
  input wire logic [11:0] req_row_in, // row
  input wire logic [7:0] req_col_in, // column
  input wire logic req_auto_pre_in, // close row by itself
  input wire logic [15:0] req_wdata_in, // write data
  input wire logic [1:0] req_wmask_in, // 1 masks a byte
  output logic rsp_valid_out, // read word waiting
  input wire logic rsp_ready_in, // user takes word
  output logic [15:0] rsp_data_out, // read word
  input wire logic sleep_in, // request power-down
  output logic busy_out // not idle
);
  if (CAS_LAT < 2 || CAS_LAT > 3 || T_RCD_CYC < 1 || T_RCD_CYC > 15 ||
      T_RP_CYC < 1 || T_RP_CYC > 14 || T_WAKE_CYC <= `SDPI_CKE_SYNC ||
      T_WAKE_CYC > 15) begin : g_chk
    $error("sdpi_ctl parameter out of range");
  end

  typedef enum logic [3:0] {
    C_INIT_PRE = 4'b0000,
    C_INIT_LMR = 4'b0001,
    C_IDLE     = 4'b0010,
    C_ACCESS   = 4'b0011,
    C_DATA     = 4'b0100,
    C_PRE      = 4'b0101,
    C_SLEEP    = 4'b0110,
    C_WAKE     = 4'b0111
  } sdpi_cst_t;

  typedef struct packed {
    sdpi_cst_t st;
    logic [3:0] cnt;
    logic cke;
    sdpi_cmd_t cmd;
    logic [1:0] ba;
    logic [11:0] addr;
    logic [1:0] dqm;
    logic [15:0] dq;
    logic [1:0] oe;
    logic wr;
    logic ap;
    logic [1:0] bank;
    logic [7:0] col;
    logic [15:0] wd;
    logic [1:0] wm;
    logic [1:0][15:0] bq;
    logic [1:0] bcnt;
    logic bhead;
  } sdpi_ctl_st_t;

  localparam sdpi_ctl_st_t RST = '{st: C_INIT_PRE, cke: 1'b1,
    cmd: SDPI_NOP, default: '0};
  localparam logic [11:0] MODE_OP = 12'((CAS_LAT << `SDPI_CL_LSB));

  sdpi_ctl_st_t s, n;
  logic pop;

  assign req_ready_out = (s.st == C_IDLE) && !sleep_in;
  assign rsp_valid_out = (s.bcnt != 2'b00);
  assign rsp_data_out = s.bq[s.bhead];
  assign busy_out = (s.st != C_IDLE);
  assign pop = rsp_valid_out && rsp_ready_in;
  // every pin comes straight from a flip-flop
  assign pin.cke = s.cke;
  assign {pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n} = s.cmd;
  assign pin.ba = s.ba;
  assign pin.addr = s.addr;
  assign pin.dqm = s.dqm;
  assign pin.ctl_dq = s.dq;
  assign pin.ctl_dq_oe = s.oe;

  always_comb begin
    n = s;
    n.cmd = SDPI_NOP;
    n.oe = 2'b00;
    n.dqm = 2'b00;
    if (pop) begin
      n.bhead = ~s.bhead;
      n.bcnt = s.bcnt - 2'b01;
    end
    case (s.st)
      C_INIT_PRE: begin
        n.cmd = SDPI_PRE;
        n.addr = 12'h400;
        n.cnt = 4'(T_RP_CYC);
        n.st = C_INIT_LMR;
      end
      C_INIT_LMR: begin
        if (s.cnt != 4'h0) n.cnt = s.cnt - 4'h1;
        else begin
          n.cmd = SDPI_LMR;
          n.addr = MODE_OP;
          n.st = C_IDLE;
        end
      end
      C_IDLE: begin
        if (sleep_in) begin
          n.cke = 1'b0;
          n.st = C_SLEEP;
        end else if (req_valid_in) begin
          n.wr = req_write_in;
          n.ap = req_auto_pre_in;
          n.bank = req_bank_in;
          n.col = req_col_in;
          n.wd = req_wdata_in;
          n.wm = req_wmask_in;
          n.cmd = SDPI_ACT;
          n.ba = req_bank_in;
          n.addr = req_row_in;
          n.cnt = 4'(T_RCD_CYC - 1);
          n.st = C_ACCESS;
        end
      end
      C_ACCESS: begin
        n.ba = s.bank;
        n.addr = {1'b0, s.ap, 2'b00, s.col};
        if (s.cnt != 4'h0) n.cnt = s.cnt - 4'h1;
        else if (s.wr) begin
          n.cmd = SDPI_WR;
          n.dq = s.wd;
          n.oe = 2'b11;
          n.dqm = s.wm;
          n.st = C_PRE;
          // spare count: the close follows the data cycle, never overlaps
          n.cnt = 4'(T_RP_CYC + 1);
        end else if (s.bcnt != 2'b10) begin
          // no read issued without room, so a stalled user loses nothing
          n.cmd = SDPI_RD;
          n.cnt = 4'(CAS_LAT);
          n.st = C_DATA;
        end
      end
      C_DATA: begin
        if (s.cnt != 4'h0) n.cnt = s.cnt - 4'h1;
        else begin
          n.bq[s.bhead ^ s.bcnt[0]] = pin.dq;
          n.bcnt = n.bcnt + 2'b01;
          n.st = C_PRE;
          n.cnt = 4'(T_RP_CYC);
        end
      end
      C_PRE: begin
        // an explicit close only where the row was left open
        if (!s.ap && s.cmd != SDPI_PRE && s.cnt == 4'(T_RP_CYC) &&
            s.oe == 2'b00) begin
          n.cmd = SDPI_PRE;
          n.ba = s.bank;
          n.addr = 12'h000;
          n.ap = 1'b1;
        end else if (s.cnt != 4'h0) n.cnt = s.cnt - 4'h1;
        else n.st = C_IDLE;
      end
      C_SLEEP: begin
        if (!sleep_in) begin
          n.cke = 1'b1;
          n.cnt = 4'(T_WAKE_CYC);
          n.st = C_WAKE;
        end
      end
      C_WAKE: begin
        if (s.cnt != 4'h0) n.cnt = s.cnt - 4'h1;
        else n.st = C_IDLE;
      end
      default: n.st = C_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) s <= RST;
    else s <= n;
  end
endmodule // sdpi_ctl

/* rtl/sdpi_dev.sv */
// sdpi_dev: dram device end; command decode, bank rows, op-code, bursts,
// byte masks and the low-activity states.
// assumes: same clock as the controller; cke may change at any time.
`timescale 1ns/1ps
`include "sdpi_defines.svh"
module sdpi_dev import sdpi_pkg::*; #(
  parameter int MEM_ROW_BITS = 2
) (
  input wire logic clk_sys_in, // system clock
  input wire logic rstn_in, // async reset, active low
  sdpi_if.dev pin, // memory pins
  output logic [1:0] pwr_state_out, // low-activity state
  output logic [3:0] bank_open_out, // banks with open row
  output logic [11:0] mode_out, // loaded op-code
  output logic burst_out // burst in progress
);
  if (MEM_ROW_BITS < 1 || MEM_ROW_BITS > `SDPI_ROW_W) begin : g_chk
    $error("MEM_ROW_BITS out of range");
  end

  localparam int AW = `SDPI_BANK_W + MEM_ROW_BITS + `SDPI_COL_W;

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cke_sync;
    logic cke_on;
    sdpi_pwr_t pwr;
    logic last_ref;
    logic [`SDPI_BANKS-1:0] open;
    logic [`SDPI_BANKS-1:0][`SDPI_ROW_W-1:0] row;
    logic [`SDPI_ROW_W-1:0] mode;
    logic bact;
    logic bwr;
    logic bap;
    logic [`SDPI_BANK_W-1:0] bbank;
    logic [`SDPI_COL_W-1:0] bcol;
    logic [8:0] bleft;
    logic [1:0] rv;
    logic [1:0][`SDPI_DQ_W-1:0] rd;
    logic [`SDPI_DQM_W-1:0] dqm_d;
    logic [`SDPI_DQ_W-1:0] dq;
    logic [`SDPI_DQM_W-1:0] oe;
  } sdpi_dev_st_t;

  // synchroniser starts high so a held-high enable is not seen to fall
  localparam sdpi_dev_st_t RST = '{cke_sync: 3'b111, cke_on: 1'b1,
    pwr: SDPI_RUN, mode: `SDPI_MODE_RST, default: '0};

  sdpi_dev_st_t s, n;
  sdpi_cmd_t cmd;
  logic [`SDPI_DQ_W-1:0] mem [0:(2**AW)-1];
  logic mem_we;
  logic [`SDPI_DQM_W-1:0] mem_be;
  logic [AW-1:0] mem_a;
  logic go;
  logic go_wr;
  logic go_ap;
  logic [`SDPI_BANK_W-1:0] go_bank;
  logic [`SDPI_COL_W-1:0] go_col;
  logic [8:0] go_left;
  logic cl3;

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  // full page wraps inside the row's 256 columns
  function automatic logic [8:0] burst_len(input logic [2:0] code);
    case (code)
      3'b000: return 9'h001;
      3'b001: return 9'h002;
      3'b010: return 9'h004;
      3'b011: return 9'h008;
      3'b111: return 9'h100;
      default: return 9'h001;
    endcase
  endfunction

  // only the low row bits are stored; higher rows alias
  function automatic logic [AW-1:0] mem_index(
      input logic [`SDPI_BANK_W-1:0] b,
      input logic [`SDPI_ROW_W-1:0] r,
      input logic [`SDPI_COL_W-1:0] c);
    return {b, r[MEM_ROW_BITS-1:0], c};
  endfunction

  // -----------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------
  assign cl3 = (s.mode[`SDPI_CL_LSB +: 3] == 3'b011);

  always_comb begin
    n = s;
    cmd = sdpi_decode(pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n);
    go = 1'b0;
    go_wr = s.bwr;
    go_ap = s.bap;
    go_bank = s.bbank;
    go_col = s.bcol;
    go_left = s.bleft;
    mem_we = 1'b0;
    mem_be = ~pin.dqm;
    mem_a = '0;
    // three stages; only the last two are compared
    n.cke_sync = {s.cke_sync[1:0], pin.cke};
    if (s.cke_sync[2] == s.cke_sync[1])
      n.cke_on = s.cke_sync[2];
    if (s.cke_on && !n.cke_on)
      n.pwr = s.bact ? SDPI_SUSP :
        (s.last_ref ? SDPI_SREF : SDPI_PDN);
    else if (n.cke_on)
      n.pwr = SDPI_RUN;

    // an ignored edge freezes everything but the synchroniser and the power state
    if (s.cke_on) begin
      // read return: mask taken one edge before the word is launched
      n.dqm_d = pin.dqm;
      n.rv = {s.rv[0], 1'b0};
      n.rd[1] = s.rd[0];
      if (cl3 ? s.rv[1] : s.rv[0]) begin
        n.dq = cl3 ? s.rd[1] : s.rd[0];
        n.oe = ~s.dqm_d;
      end else begin
        n.oe = '0;
      end

      // deselect leaves the refresh marker as it was
      if (cmd != SDPI_DESEL)
        n.last_ref = (cmd == SDPI_REF);
      go = s.bact;
      case (cmd)
        SDPI_ACT: begin
          n.open[pin.ba] = 1'b1;
          n.row[pin.ba] = pin.addr;
        end
        SDPI_RD, SDPI_WR: begin
          go = 1'b1;
          go_wr = (cmd == SDPI_WR);
          go_ap = pin.addr[`SDPI_AP_BIT];
          go_bank = pin.ba;
          go_col = pin.addr[`SDPI_COL_W-1:0];
          go_left = burst_len(s.mode[`SDPI_BL_LSB +: 3]);
          if (go_wr && s.mode[`SDPI_WB_SINGLE_BIT])
            go_left = 9'h001;
        end
        SDPI_PRE: begin
          if (pin.addr[`SDPI_AP_BIT]) begin
            n.open = '0;
            go = 1'b0;
          end else begin
            n.open[pin.ba] = 1'b0;
            if (pin.ba == s.bbank)
              go = 1'b0;
          end
        end
        SDPI_BST: go = 1'b0;
        SDPI_LMR: n.mode = pin.addr;
        default: ;
      endcase

      // one beat per valid edge; a closed bank takes no access
      mem_a = mem_index(go_bank, s.row[go_bank], go_col);
      if (go && !s.open[go_bank])
        go = 1'b0;
      n.bact = go && (go_left > 9'h001);
      if (go) begin
        n.bwr = go_wr;
        n.bap = go_ap;
        n.bbank = go_bank;
        n.bcol = go_col + 8'h01;
        n.bleft = go_left - 9'h001;
        if (go_wr) begin
          mem_we = 1'b1;
        end else begin
          n.rv[0] = 1'b1;
          n.rd[0] = mem[mem_a];
        end
        if (go_left == 9'h001 && go_ap)
          n.open[go_bank] = 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) s <= RST;
    else s <= n;
  end

  // array contents are unknown after power-up, as in the real part
  always_ff @(posedge clk_sys_in) begin
    if (mem_we) begin
      for (int b = 0; b < `SDPI_DQM_W; b++) begin
        if (mem_be[b])
          mem[mem_a][8*b +: 8] <= pin.dq[8*b +: 8];
      end
    end
  end

  // -----------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------
  assign pin.dev_dq = s.dq;
  assign pin.dev_dq_oe = s.oe;
  assign pwr_state_out = s.pwr;
  assign bank_open_out = s.open;
  assign mode_out = s.mode;
  assign burst_out = s.bact;
endmodule // sdpi_dev

/* sim/sdpi_props.sv */
// sdpi_props: pin-level checks between the controller and device ends.
// assumes: placed beside sdpi_if; cas latency 2, burst length 1.
`timescale 1ns/1ps
module sdpi_props (
  input wire logic clk_sys_in, // system clock
  input wire logic rstn_in, // async reset, active low
  input wire logic cke, // clock enable
  input wire logic cs_n, // chip select
  input wire logic ras_n, // row strobe
  input wire logic cas_n, // column strobe
  input wire logic we_n, // write strobe
  input wire logic [1:0] ba, // bank
  input wire logic [11:0] addr, // address or op-code
  input wire logic [1:0] dqm, // byte masks
  input wire logic [1:0] ctl_dq_oe, // controller byte drive
  input wire logic [1:0] dev_dq_oe // device byte drive
);
  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  logic sel;
  logic rd;
  logic wr;
  logic act;
  logic pre;
  logic lmr;
  logic [1:0] act_bank;
  assign sel = !cs_n && cke;
  assign rd = sel && {ras_n, cas_n, we_n} == 3'b101;
  assign wr = sel && {ras_n, cas_n, we_n} == 3'b100;
  assign act = sel && {ras_n, cas_n, we_n} == 3'b011;
  assign pre = sel && {ras_n, cas_n, we_n} == 3'b010;
  assign lmr = sel && {ras_n, cas_n, we_n} == 3'b000;
  // bank of the last activate, held for the column command
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in)
      act_bank <= 2'h0;
    else if (act)
      act_bank <= ba;
  end
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  a_rd_mask_lat: assert property (
    rd |-> ##2 dev_dq_oe == ~$past(dqm, 2))
    else $error("read byte enable not the mask two clocks back");
  a_dev_quiet: assert property (
    dev_dq_oe != 2'b00 |-> $past(rd, 2))
    else $error("device drove data without a read");
  a_wr_drives: assert property (
    wr |-> ctl_dq_oe == 2'b11)
    else $error("write issued without write data on both bytes");
  a_rd_hands_off: assert property (
    rd |-> (ctl_dq_oe == 2'b00)[*4])
    else $error("controller drove data during a read");
  a_oe_excl: assert property (
    (dev_dq_oe & ctl_dq_oe) == 2'b00)
    else $error("both ends drive one byte");
  a_act_col: assert property (
    act |-> ##[2:8] ((rd || wr) && ba == act_bank))
    else $error("no column command to the activated bank");
  a_wr_close: assert property (
    wr && !addr[10] |-> ##2 pre && !addr[10] && ba == $past(ba, 2))
    else $error("write without auto close not followed by bank close");
  a_rd_close: assert property (
    rd && !addr[10] |-> ##4 pre && !addr[10] && ba == $past(ba, 4))
    else $error("read without auto close not followed by bank close");
  a_lmr_code: assert property (
    lmr |-> addr == 12'h020)
    else $error("mode op-code not latency two, burst one");
endmodule // sdpi_props

/* sim/sdpi_bench.sv */
// sdpi_bench: both ends joined back to back; random and corner accesses.
// assumes: default parameters; rows kept below 4 so none alias.
`timescale 1ns/1ps
module sdpi_bench;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_ap = 1'b0;
  logic [1:0] req_bank = 2'h0, req_wmask = 2'h0;
  logic [11:0] req_row = 12'h000;
  logic [7:0] req_col = 8'h00;
  logic [15:0] req_wdata = 16'h0000;
  logic rsp_ready = 1'b0, sleep = 1'b0;
  logic req_ready, rsp_valid, busy, burst;
  logic [15:0] rsp_data;
  logic [1:0] pwr;
  logic [3:0] bank_open;
  logic [11:0] mode;
  int failures = 0, checks_done = 0;
  logic [31:0] seed = 32'h0000_9182;
  logic [15:0] mem [int];
  always #2 clk_sys_in = ~clk_sys_in;
  // -----------------------------------------------------------------
  // both ends and the checker
  // -----------------------------------------------------------------
  sdpi_if link ();
  sdpi_ctl u_sdpi_ctl (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .pin(link), .req_valid_in(req_valid), .req_ready_out(req_ready),
    .req_write_in(req_write), .req_bank_in(req_bank),
    .req_row_in(req_row), .req_col_in(req_col), .req_auto_pre_in(req_ap),
    .req_wdata_in(req_wdata), .req_wmask_in(req_wmask),
    .rsp_valid_out(rsp_valid), .rsp_ready_in(rsp_ready),
    .rsp_data_out(rsp_data), .sleep_in(sleep), .busy_out(busy));
  sdpi_dev u_sdpi_dev (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .pin(link), .pwr_state_out(pwr), .bank_open_out(bank_open),
    .mode_out(mode), .burst_out(burst));
  sdpi_props u_sdpi_props (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
    .addr(link.addr), .dqm(link.dqm), .ctl_dq_oe(link.ctl_dq_oe),
    .dev_dq_oe(link.dev_dq_oe));
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // masked bytes keep the old contents
  function automatic logic [15:0] merge(logic [15:0] old,
      logic [15:0] nw, logic [1:0] m);
    return {m[1] ? old[15:8] : nw[15:8], m[0] ? old[7:0] : nw[7:0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic req(input logic w, input logic [11:0] k, input logic ap,
      input logic [15:0] d, input logic [1:0] m);
    int n;
    n = 0;
    {req_write, req_ap, req_wdata, req_wmask} = {w, ap, d, m};
    {req_bank, req_row, req_col} = {k[11:10], 10'h000, k[9:0]};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n == 300)
      failures++;
    @(negedge clk_sys_in);
    req_valid = 1'b0;
    if (w)
      mem[int'(k)] = merge(mem[int'(k)], d, m);
    // a clock passes before valid may rise again
    @(negedge clk_sys_in);
  endtask
  task automatic pop(input logic [15:0] exp);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n == 300)
      failures++;
    check(rsp_data, exp);
    rsp_ready = 1'b1;
    @(negedge clk_sys_in);
    rsp_ready = 1'b0;
    @(negedge clk_sys_in);
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n == 300)
      failures++;
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
  initial begin
    logic [31:0] r;
    logic [11:0] k;
    repeat (4) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    idle();
    check(16'(mode), 16'h0020);
    check(16'(pwr), 16'h0000);
    // first eight share column 0, four banks to a row in rows 0 and 1, so a bank slip shows
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      k[11:10] = i[1:0];
      k[9:8] = (i < 8) ? {1'b0, i[2]} : r[9:8];
      k[7:0] = (i < 8) ? 8'h00 : ((i == 8) ? 8'hff : r[7:0]);
      req(1'b1, k, r[20], r[15:0], 2'b00);
      req(1'b1, k, r[21], r[31:16], i[1:0]);
      req(1'b0, k, r[22], 16'h0000, 2'b00);
      pop(mem[int'(k)]);
      idle();
      check(16'(bank_open), 16'h0000);
    end
    foreach (mem[j]) begin
      req(1'b0, j[11:0], j[0], 16'h0000, 2'b00);
      pop(mem[j]);
    end
    $display("test access done");
    // receiver stalls: two words wait, the third must not be lost
    req(1'b0, 12'h000, 1'b0, 16'h0000, 2'b00);
    req(1'b0, 12'h400, 1'b1, 16'h0000, 2'b00);
    repeat (20) @(negedge clk_sys_in);
    check(16'(rsp_valid), 16'h0001);
    fork
      req(1'b0, 12'h800, 1'b0, 16'h0000, 2'b00);
      begin
        repeat (5) @(negedge clk_sys_in);
        pop(mem[0]);
        pop(mem[12'h400]);
        pop(mem[12'h800]);
      end
    join
    $display("test stall done");
    idle();
    sleep = 1'b1;
    repeat (12) @(negedge clk_sys_in);
    check(16'(req_ready), 16'h0000);
    check(16'(link.cke), 16'h0000);
    check(16'(pwr), 16'h0001);
    sleep = 1'b0;
    repeat (12) @(negedge clk_sys_in);
    check(16'(pwr), 16'h0000);
    idle();
    req(1'b0, 12'h000, 1'b1, 16'h0000, 2'b00);
    pop(mem[0]);
    $display("test sleep done");
    report_and_stop();
  end
endmodule // sdpi_bench
